// file: pkg/l2_lookup_pkg.sv
// Constants, table entry layout and encodings for the layer-2 destination lookup engine.
// Assumes one core clock and an address table whose read port sits outside this block.
package l2_lookup_pkg;

   // -----------------------------------------------------------------
   // Widths and table geometry
   // -----------------------------------------------------------------
   localparam int MAC_W         = 48;
   localparam int VID_W         = 12;
   localparam int KEY_W         = MAC_W + VID_W;
   localparam int PORT_NUM      = 9;
   localparam int PORT_ID_W     = 4;
   localparam int TC_W          = 3;
   localparam int HASH_W        = 16;
   localparam int INDEX_W       = 10;
   localparam int BINS          = 4;
   localparam int BINS_PER_READ = 2;

   // -----------------------------------------------------------------
   // Table entry layout, common to unicast and multicast entries
   // -----------------------------------------------------------------
   localparam int E_MAC_LSB    = 0;
   localparam int E_FWD_LSB    = 48;  // Port identifier or multicast port mask.
   localparam int E_FWD_W      = 9;
   localparam int E_TC_LSB     = 57;
   localparam int E_AGE_BIT    = 60;
   localparam int E_STATIC_BIT = 61;
   localparam int E_VALID_BIT  = 62;
   localparam int E_VID_LSB    = 63;
   localparam int ENTRY_W      = 75;

   // -----------------------------------------------------------------
   // Address classes and hash
   // -----------------------------------------------------------------
   localparam int                MCAST_BIT     = 40;  // Group bit of the first octet.
   localparam logic [39:0]       RSVD_PREFIX   = 40'h0180c20000;
   localparam logic [7:0]        RSVD_LAST     = 8'h2f;
   localparam logic [23:0]       IPMC_PREFIX   = 24'h01005e;
   localparam logic [HASH_W-1:0] CRC_POLY      = 16'h1021;
   localparam logic [HASH_W-1:0] CRC_INIT      = 16'hffff;

   // -----------------------------------------------------------------
   // Encodings
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_HASH = 5'h02,
      ST_RD0  = 5'h04,
      ST_RD1  = 5'h08,
      ST_RD2  = 5'h10
   } lookup_state_t;

   typedef enum logic [2:0] {
      FWD_RESERVED  = 3'h0,
      FWD_MULTIPORT = 3'h1,
      FWD_UNICAST   = 3'h2,
      FWD_MCAST     = 3'h3,
      FWD_FAIL      = 3'h4,
      FWD_FLOOD     = 3'h5,
      FWD_DROP      = 3'h6
   } fwd_kind_t;

endpackage : l2_lookup_pkg

// file: hdl/l2_address_resolution_lookup.sv
// Destination lookup engine: hashes each frame key that is not reserved or multiport into the address_resolution_table,
// compares the four bins of the bucket and issues one forwarding result per frame.
// Assumes the table read port answers one cycle after a read strobe with two bins.
`timescale 1ns/1ps

module l2_address_resolution_lookup
   import l2_lookup_pkg::*;
#(
   parameter int MP_NUM = 2
) (
   // Clock and reset
   input  wire logic                                     clock,
   input  wire logic                                     rst_n,
   // Frame header request from the ingress pipeline
   input  wire logic                                     req_valid,
   output logic                                          req_ready,
   input  wire logic [l2_lookup_pkg::MAC_W-1:0]          req_da,
   input  wire logic [l2_lookup_pkg::VID_W-1:0]          req_vid,
   input  wire logic [l2_lookup_pkg::PORT_ID_W-1:0]      req_src_port,
   // Configuration
   input  wire logic                                     vlan_aware_enable,
   input  wire logic                                     multiport_enable,
   input  wire logic [MP_NUM*l2_lookup_pkg::MAC_W-1:0]   multiport_addr,
   input  wire logic [MP_NUM*l2_lookup_pkg::PORT_NUM-1:0] multiport_map,
   input  wire logic                                     uc_lookup_fail_forward,
   input  wire logic [l2_lookup_pkg::PORT_NUM-1:0]       uc_fail_map,
   input  wire logic [1:0]                               mc_lookup_fail_forward,
   input  wire logic [2*l2_lookup_pkg::PORT_NUM-1:0]     mc_fail_map,
   input  wire logic [l2_lookup_pkg::PORT_NUM-1:0]       flood_eligible,
   // Address table read port
   output logic                                          tbl_rd_en,
   output logic [l2_lookup_pkg::INDEX_W-1:0]             tbl_rd_index,
   output logic                                          tbl_rd_bank,
   input  wire logic [2*l2_lookup_pkg::ENTRY_W-1:0]      tbl_rd_data,
   // Forwarding result
   output logic                                          res_valid,
   output l2_lookup_pkg::fwd_kind_t                      res_kind,
   output logic [l2_lookup_pkg::PORT_NUM-1:0]            res_port_mask,
   output logic [l2_lookup_pkg::PORT_ID_W-1:0]           res_dest_port,
   output logic [l2_lookup_pkg::TC_W-1:0]                res_traffic_class,
   output logic                                          res_tc_valid,
   output logic                                          res_hit_age
);
   import l2_lookup_pkg::*;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   lookup_state_t                 state_q;
   logic                          req_ready_q;
   logic [MAC_W-1:0]              da_q;
   logic [VID_W-1:0]              vid_q;
   logic [PORT_ID_W-1:0]          src_q;
   logic                          aware_q;
   logic                          hit_q;
   logic [ENTRY_W-1:0]            hit_entry_q;
   logic                          tbl_rd_en_q;
   logic [INDEX_W-1:0]            tbl_rd_index_q;
   logic                          tbl_rd_bank_q;
   logic                          res_valid_q;
   fwd_kind_t                     res_kind_q;
   logic [PORT_NUM-1:0]           res_mask_q;
   logic [PORT_ID_W-1:0]          res_port_q;
   logic [TC_W-1:0]               res_tc_q;
   logic                          res_tc_valid_q;
   logic                          res_age_q;

   // -----------------------------------------------------------------
   // Hash
   // -----------------------------------------------------------------

   // Serial CRC over the key, MAC first; the VID bits are skipped when not VLAN-aware.
   function automatic logic [HASH_W-1:0] key_crc(input logic [KEY_W-1:0] key,
                                                  input logic            use_vid);
      logic [HASH_W-1:0] c;
      logic              fb;
      c  = CRC_INIT;
      fb = 1'b0;
      for (int i = KEY_W - 1; i >= 0; i--) begin
         if (use_vid || i >= VID_W) begin
            fb = c[HASH_W-1] ^ key[i];
            c  = {c[HASH_W-2:0], 1'b0};
            if (fb) begin
               c = c ^ CRC_POLY;
            end
         end
      end
      return c;
   endfunction : key_crc

   logic [HASH_W-1:0] hash_w;
   assign hash_w = key_crc({da_q, vid_q}, aware_q);

   // -----------------------------------------------------------------
   // Address classification
   // -----------------------------------------------------------------
   logic                is_mcast;
   logic                is_reserved;
   logic                mc_class;
   logic [MP_NUM-1:0]   mp_match;
   logic [PORT_NUM-1:0] mp_mask;
   logic [PORT_NUM-1:0] src_onehot;

   assign is_mcast    = da_q[MCAST_BIT];
   assign is_reserved = (da_q[MAC_W-1:8] == RSVD_PREFIX) && (da_q[7:0] <= RSVD_LAST);
   // Class zero is the IP multicast range, class one every other group address.
   assign mc_class    = (da_q[MAC_W-1:MAC_W-24] != IPMC_PREFIX);
   assign src_onehot  = PORT_NUM'(1) << src_q;

   // Each programmed multiport address is compared in parallel.
   for (genvar m = 0; m < MP_NUM; m++) begin : g_mp
      assign mp_match[m] = multiport_enable &&
                           (multiport_addr[m*MAC_W +: MAC_W] == da_q);
   end

   // The lowest matching multiport slot wins; the slots should not overlap.
   always_comb begin
      mp_mask = '0;
      for (int m = MP_NUM - 1; m >= 0; m--) begin
         if (mp_match[m]) begin
            mp_mask = multiport_map[m*PORT_NUM +: PORT_NUM];
         end
      end
   end

   // -----------------------------------------------------------------
   // Bin comparison, two bins per table read
   // -----------------------------------------------------------------
   logic [BINS_PER_READ-1:0] bin_match;
   logic [ENTRY_W-1:0]       pair_entry;
   logic                     pair_hit;

   // A bin hits when valid and its stored key equals the frame key.
   for (genvar b = 0; b < BINS_PER_READ; b++) begin : g_bin
      logic [ENTRY_W-1:0] e;
      assign e = tbl_rd_data[b*ENTRY_W +: ENTRY_W];
      assign bin_match[b] = e[E_VALID_BIT] &&
                            (e[E_MAC_LSB +: MAC_W] == da_q) &&
                            (!aware_q || (e[E_VID_LSB +: VID_W] == vid_q));
   end

   // Lower bin number takes precedence when two bins hold the same key.
   always_comb begin
      pair_hit   = |bin_match;
      pair_entry = '0;
      for (int b = BINS_PER_READ - 1; b >= 0; b--) begin
         if (bin_match[b]) begin
            pair_entry = tbl_rd_data[b*ENTRY_W +: ENTRY_W];
         end
      end
   end

   // -----------------------------------------------------------------
   // Forwarding decision
   // -----------------------------------------------------------------
   logic                 early_done;
   logic                 final_hit;
   logic [ENTRY_W-1:0]   final_entry;
   fwd_kind_t            kind_d;
   logic [PORT_NUM-1:0]  mask_d;
   logic [PORT_ID_W-1:0] port_d;
   logic [TC_W-1:0]      tc_d;
   logic                 tc_valid_d;
   logic                 age_d;

   // Reserved and multiport frames are decided before any table read is spent.
   assign early_done  = (is_mcast && is_reserved) || (|mp_match);
   assign final_hit   = hit_q || pair_hit;
   assign final_entry = hit_q ? hit_entry_q : pair_entry;

   always_comb begin
      kind_d     = FWD_FLOOD;
      mask_d     = flood_eligible & ~src_onehot;
      port_d     = src_q;
      tc_d       = final_entry[E_TC_LSB +: TC_W];
      tc_valid_d = 1'b0;
      age_d      = 1'b0;
      if (is_mcast && is_reserved) begin
         // The low four address bits in the port field let the reserved handler pick its action.
         kind_d = FWD_RESERVED;
         mask_d = '0;
         port_d = PORT_ID_W'(da_q[5:0]);
      end else if (|mp_match) begin
         kind_d = FWD_MULTIPORT;
         mask_d = mp_mask;
      end else if (final_hit) begin
         tc_valid_d = final_entry[E_STATIC_BIT];
         if (is_mcast) begin
            kind_d = FWD_MCAST;
            mask_d = final_entry[E_FWD_LSB +: E_FWD_W];
            age_d  = 1'b0;
         end else begin
            port_d = final_entry[E_FWD_LSB +: PORT_ID_W];
            age_d  = final_entry[E_AGE_BIT];
            if (port_d == src_q) begin
               kind_d = FWD_DROP;
               mask_d = '0;
            end else begin
               kind_d = FWD_UNICAST;
               mask_d = PORT_NUM'(1) << port_d;
            end
         end
      end else if (!is_mcast && uc_lookup_fail_forward) begin
         kind_d = FWD_FAIL;
         mask_d = uc_fail_map;
      end else if (is_mcast && mc_lookup_fail_forward[mc_class]) begin
         kind_d = FWD_FAIL;
         mask_d = mc_fail_map[mc_class*PORT_NUM +: PORT_NUM];
      end
   end

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------

   // One frame at a time; the ready flop holds the source off until the result leaves.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_q     <= ST_IDLE;
         req_ready_q <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (req_valid && req_ready_q) begin
                  state_q     <= ST_HASH;
                  req_ready_q <= 1'b0;
               end
            end
            ST_HASH: begin
               if (early_done) begin
                  state_q     <= ST_IDLE;
                  req_ready_q <= 1'b1;
               end else begin
                  state_q <= ST_RD0;
               end
            end
            ST_RD0: begin
               state_q <= ST_RD1;
            end
            ST_RD1: begin
               state_q <= ST_RD2;
            end
            ST_RD2: begin
               state_q     <= ST_IDLE;
               req_ready_q <= 1'b1;
            end
            default: begin
               state_q     <= ST_IDLE;
               req_ready_q <= 1'b1;
            end
         endcase
      end
   end

   // Frame key capture.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         da_q    <= '0;
         vid_q   <= '0;
         src_q   <= '0;
         aware_q <= 1'b0;
      end else if (state_q == ST_IDLE && req_valid && req_ready_q) begin
         da_q    <= req_da;
         vid_q   <= req_vid;
         src_q   <= req_src_port;
         aware_q <= vlan_aware_enable; // Held per frame so a config change cannot split a key.
      end
   end

   // Table reads: bins 0 and 1, then bins 2 and 3 on the next cycle.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tbl_rd_en_q    <= 1'b0;
         tbl_rd_index_q <= '0;
         tbl_rd_bank_q  <= 1'b0;
      end else begin
         tbl_rd_en_q   <= 1'b0;
         tbl_rd_bank_q <= 1'b0;
         if (state_q == ST_HASH && !early_done) begin
            tbl_rd_en_q    <= 1'b1;
            tbl_rd_index_q <= hash_w[INDEX_W-1:0];
         end else if (state_q == ST_RD0) begin
            tbl_rd_en_q   <= 1'b1;
            tbl_rd_bank_q <= 1'b1;
         end
      end
   end

   // The first pair's hit is kept so the second pair cannot displace it.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hit_q       <= 1'b0;
         hit_entry_q <= '0;
      end else if (state_q == ST_HASH) begin
         hit_q <= 1'b0;
      end else if (state_q == ST_RD1) begin
         hit_q       <= pair_hit;
         hit_entry_q <= pair_entry;
      end
   end

   // Result registers, one pulse per frame.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         res_valid_q    <= 1'b0;
         res_kind_q     <= FWD_FLOOD;
         res_mask_q     <= '0;
         res_port_q     <= '0;
         res_tc_q       <= '0;
         res_tc_valid_q <= 1'b0;
         res_age_q      <= 1'b0;
      end else begin
         res_valid_q <= (state_q == ST_HASH && early_done) || (state_q == ST_RD2);
         if ((state_q == ST_HASH && early_done) || state_q == ST_RD2) begin
            res_kind_q     <= kind_d;
            res_mask_q     <= mask_d;
            res_port_q     <= port_d;
            res_tc_q       <= tc_d;
            res_tc_valid_q <= tc_valid_d;
            res_age_q      <= age_d;
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign req_ready         = req_ready_q;
   assign tbl_rd_en         = tbl_rd_en_q;
   assign tbl_rd_index      = tbl_rd_index_q;
   assign tbl_rd_bank       = tbl_rd_bank_q;
   assign res_valid         = res_valid_q;
   assign res_kind          = res_kind_q;
   assign res_port_mask     = res_mask_q;
   assign res_dest_port     = res_port_q;
   assign res_traffic_class = res_tc_q;
   assign res_tc_valid      = res_tc_valid_q;
   assign res_hit_age       = res_age_q;

endmodule : l2_address_resolution_lookup

// file: tb/l2_table_model.sv
// Behavioural address table that answers the lookup engine's read port.
// Assumes the bench loads entries through the write port before a lookup.
`timescale 1ns/1ps

module l2_table_model
   import l2_lookup_pkg::*;
(
   // Clock
   input  wire logic                                  clock,
   // Read port facing the engine
   input  wire logic                                  tbl_rd_en,
   input  wire logic [l2_lookup_pkg::INDEX_W-1:0]     tbl_rd_index,
   input  wire logic                                  tbl_rd_bank,
   output logic      [2*l2_lookup_pkg::ENTRY_W-1:0]   tbl_rd_data,
   // Loading port for the bench
   input  wire logic                                  wr_en,
   input  wire logic [l2_lookup_pkg::INDEX_W-1:0]     wr_index,
   input  wire logic [1:0]                            wr_bin,
   input  wire logic [l2_lookup_pkg::ENTRY_W-1:0]     wr_entry
);
   import l2_lookup_pkg::*;

   logic [ENTRY_W-1:0] mem_q [0:1023][0:3];

   // All bins start empty so that an unloaded bucket misses.
   initial begin
      foreach (mem_q[i, j]) mem_q[i][j] = '0;
   end

   // Bench loading, one bin at a time.
   always @(posedge clock) begin
      if (wr_en) begin
         mem_q[wr_index][wr_bin] <= wr_entry;
      end
   end

   // Two bins per strobe; data turns to its inverse outside the answer cycle,
   // so an engine sampling one cycle late never sees stale bins.
   always @(posedge clock) begin
      if (tbl_rd_en) begin
         tbl_rd_data <= {mem_q[tbl_rd_index][{tbl_rd_bank, 1'b1}],
                         mem_q[tbl_rd_index][{tbl_rd_bank, 1'b0}]};
      end else begin
         tbl_rd_data <= ~tbl_rd_data;
      end
   end

endmodule : l2_table_model

// file: tb/l2_lookup_chk.sv
// Concurrent checks on the ports of the destination lookup engine.
// Assumes it is bound to the engine and that all ports share one clock.
`timescale 1ns/1ps

module l2_lookup_chk
   import l2_lookup_pkg::*;
(
   // Clock and reset
   input  wire logic                             clock,
   input  wire logic                             rst_n,
   // Request, configuration and table port
   input  wire logic                             req_valid,
   input  wire logic                             req_ready,
   input  wire logic [l2_lookup_pkg::PORT_NUM-1:0] flood_eligible,
   input  wire logic                             tbl_rd_en,
   input  wire logic [l2_lookup_pkg::INDEX_W-1:0] tbl_rd_index,
   input  wire logic                             tbl_rd_bank,
   // Result
   input  wire logic                             res_valid,
   input  wire l2_lookup_pkg::fwd_kind_t         res_kind,
   input  wire logic [l2_lookup_pkg::PORT_NUM-1:0] res_port_mask,
   input  wire logic                             res_tc_valid,
   input  wire logic                             res_hit_age
);
   import l2_lookup_pkg::*;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_bank_order;
      tbl_rd_en && !tbl_rd_bank |=> tbl_rd_en && tbl_rd_bank ##1 !tbl_rd_en;
   endproperty
   a_bank_order: assert property (p_bank_order)
      else $error("bank reads out of order");

   property p_index_hold;
      tbl_rd_en && tbl_rd_bank |-> $stable(tbl_rd_index);
   endproperty
   a_index_hold: assert property (p_index_hold)
      else $error("index moved between reads");

   property p_answer;
      req_valid && req_ready |-> ##[2:5] res_valid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("result missing or late");

   property p_fail_after;
      res_valid && res_kind == FWD_FAIL |-> $past(tbl_rd_en, 2) && $past(tbl_rd_bank, 2);
   endproperty
   a_fail_after: assert property (p_fail_after)
      else $error("failure before all bins read");

   property p_hit_late;
      res_valid && res_kind inside {FWD_UNICAST, FWD_MCAST}
         |-> $past(tbl_rd_en, 3) && !$past(tbl_rd_bank, 3);
   endproperty
   a_hit_late: assert property (p_hit_late)
      else $error("hit without a bucket read");

   property p_early;
      res_valid && res_kind inside {FWD_RESERVED, FWD_MULTIPORT} |-> !$past(tbl_rd_en);
   endproperty
   a_early: assert property (p_early)
      else $error("early result after a read");

   property p_drop;
      res_valid && res_kind == FWD_DROP |-> res_port_mask == 9'h000;
   endproperty
   a_drop: assert property (p_drop)
      else $error("drop with ports set");

   property p_flood;
      res_valid && res_kind == FWD_FLOOD |-> (res_port_mask & ~flood_eligible) == 9'h000;
   endproperty
   a_flood: assert property (p_flood)
      else $error("flood to ineligible port");

   property p_tc;
      res_valid && res_tc_valid |-> res_kind inside {FWD_UNICAST, FWD_MCAST, FWD_DROP};
   endproperty
   a_tc: assert property (p_tc)
      else $error("class valid without hit");

   property p_age;
      res_valid && !(res_kind inside {FWD_UNICAST, FWD_DROP}) |-> !res_hit_age;
   endproperty
   a_age: assert property (p_age)
      else $error("age set without unicast hit");

   c_unicast: cover property (res_valid && res_kind == FWD_UNICAST);
   c_fail: cover property (res_valid && res_kind == FWD_FAIL);
   c_reserved: cover property (res_valid && res_kind == FWD_RESERVED);

endmodule : l2_lookup_chk

// file: tb/l2_address_resolution_lookup_tb_top.sv
// Self-checking bench for the destination lookup engine with a table model.
// Assumes the engine contract of one request per result and a one-cycle table answer.
`timescale 1ns/1ps

module l2_address_resolution_lookup_tb_top;
   import l2_lookup_pkg::*;

   logic clock, rst_n, req_valid, req_ready, vlan_aware_enable, multiport_enable;
   logic uc_lookup_fail_forward, tbl_rd_en, tbl_rd_bank, res_valid, res_tc_valid, res_hit_age;
   logic wr_en;
   logic [47:0] req_da;
   logic [11:0] req_vid;
   logic [3:0] req_src_port, res_dest_port;
   logic [95:0] multiport_addr;
   logic [17:0] multiport_map, mc_fail_map;
   logic [8:0] uc_fail_map, flood_eligible, res_port_mask;
   logic [1:0] mc_lookup_fail_forward, wr_bin;
   logic [9:0] tbl_rd_index, wr_index;
   logic [149:0] tbl_rd_data;
   logic [74:0] wr_entry;
   logic [2:0] res_traffic_class;
   fwd_kind_t res_kind;
   int fail_count = 0, cmp_count = 0;
   localparam logic [47:0] UC = 48'h00123456789a, MC = 48'h01005e010203,
                           MPA = 48'h020000000011;

   // Free-running core clock, 8 ns period.
   initial clock = 1'b0;
   always #4 clock = ~clock;

   l2_address_resolution_lookup i_l2_address_resolution_lookup (
      .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_da(req_da), .req_vid(req_vid), .req_src_port(req_src_port),
      .vlan_aware_enable(vlan_aware_enable), .multiport_enable(multiport_enable),
      .multiport_addr(multiport_addr), .multiport_map(multiport_map),
      .uc_lookup_fail_forward(uc_lookup_fail_forward), .uc_fail_map(uc_fail_map),
      .mc_lookup_fail_forward(mc_lookup_fail_forward), .mc_fail_map(mc_fail_map),
      .flood_eligible(flood_eligible), .tbl_rd_en(tbl_rd_en), .tbl_rd_index(tbl_rd_index),
      .tbl_rd_bank(tbl_rd_bank), .tbl_rd_data(tbl_rd_data), .res_valid(res_valid),
      .res_kind(res_kind), .res_port_mask(res_port_mask), .res_dest_port(res_dest_port),
      .res_traffic_class(res_traffic_class), .res_tc_valid(res_tc_valid),
      .res_hit_age(res_hit_age));

   l2_table_model i_l2_table_model (
      .clock(clock), .tbl_rd_en(tbl_rd_en), .tbl_rd_index(tbl_rd_index),
      .tbl_rd_bank(tbl_rd_bank), .tbl_rd_data(tbl_rd_data), .wr_en(wr_en),
      .wr_index(wr_index), .wr_bin(wr_bin), .wr_entry(wr_entry));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Reference hash, MSB first over the key; VID bits only when VLAN-aware.
   function automatic logic [9:0] hidx(input logic [47:0] da, input logic [11:0] vid,
                                       input logic aware);
      logic [15:0] c;
      logic [59:0] k;
      c = 16'hffff;
      k = {da, vid};
      for (int i = 59; i >= 0; i--) begin
         if (i >= 12 || aware) c = {c[14:0], 1'b0} ^ ((c[15] ^ k[i]) ? 16'h1021 : 16'h0000);
      end
      return c[9:0];
   endfunction : hidx

   task automatic chk(input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Loads one bin; vsa is valid, static, age; vid picks the bucket, evid is stored.
   task automatic put(input logic [47:0] mac, input logic [11:0] vid, evid,
                      input logic [1:0] bin, input logic [2:0] vsa, tc, input logic [8:0] fwd);
      @(negedge clock);
      {wr_en, wr_bin, wr_entry} = {1'b1, bin, evid, vsa, tc, fwd, mac};
      wr_index = hidx(mac, vid, vlan_aware_enable);
      @(negedge clock);
      wr_en = 1'b0;
   endtask : put

   // Holds the request until taken, then waits a bounded time for the result.
   task automatic lookup(input logic [47:0] da, input logic [11:0] vid, input logic [3:0] src);
      int n;
      @(negedge clock);
      {req_da, req_vid, req_src_port, req_valid} = {da, vid, src, 1'b1};
      for (n = 0; req_ready !== 1'b1 && n < 20; n++)
         @(negedge clock);
      @(negedge clock);
      req_valid = 1'b0;
      for (n = 0; res_valid !== 1'b1 && n < 20; n++)
         @(negedge clock);
      if (n == 20) chk(16'h0000, 16'h0001);
   endtask : lookup

   task automatic res_is(input fwd_kind_t k, input logic [8:0] m);
      chk(res_kind, k);
      chk(res_port_mask, m);
   endtask : res_is

   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      {rst_n, req_valid, wr_en, multiport_enable, mc_lookup_fail_forward} = '0;
      {vlan_aware_enable, uc_lookup_fail_forward} = 2'b11;
      uc_fail_map = 9'h10e;
      mc_fail_map = {9'h150, 9'h02b};
      flood_eligible = 9'h1bf;
      multiport_addr = {MPA, 48'h020000000010};
      multiport_map = {9'h0c3, 9'h005};
      repeat (20) @(negedge clock);
      rst_n = 1'b1;
      // A same-MAC decoy in bin 0 with another VID must not hit; bin 3 must.
      put(UC, 12'h00a, 12'h00b, 2'h0, 3'b100, 3'h0, 9'h001);
      put(UC, 12'h00a, 12'h00a, 2'h3, 3'b111, 3'h5, 9'h006);
      lookup(UC, 12'h00a, 4'h2);
      chk(res_kind, FWD_UNICAST);
      chk(res_dest_port, 4'h6);
      chk({res_tc_valid, res_traffic_class}, 4'hd);
      chk(res_hit_age, 1'b1);
      lookup(UC, 12'h00a, 4'h6);
      res_is(FWD_DROP, 9'h000);
      lookup(UC, 12'h00c, 4'h2);
      res_is(FWD_FAIL, 9'h10e);
      uc_lookup_fail_forward = 1'b0;
      lookup(UC, 12'h00c, 4'h2);
      res_is(FWD_FLOOD, 9'h1bb);
      // MAC-only key: an invalid bin is skipped, a dynamic bin hits.
      vlan_aware_enable = 1'b0;
      put(UC, 12'h000, 12'h000, 2'h0, 3'b011, 3'h1, 9'h001);
      put(UC, 12'h000, 12'h3ff, 2'h1, 3'b100, 3'h7, 9'h008);
      lookup(UC, 12'h123, 4'h2);
      chk(res_kind, FWD_UNICAST);
      chk(res_dest_port, 4'h8);
      chk({res_tc_valid, res_hit_age}, 2'h0);
      vlan_aware_enable = 1'b1;
      put(MC, 12'h00a, 12'h00a, 2'h2, 3'b111, 3'h1, 9'h1a5);
      lookup(MC, 12'h00a, 4'h0);
      res_is(FWD_MCAST, 9'h1a5);
      lookup(48'h0180c200002f, 12'h00a, 4'h0);
      res_is(FWD_RESERVED, 9'h000);
      lookup(48'h0180c2000000, 12'h00a, 4'h0);
      res_is(FWD_RESERVED, 9'h000);
      // Multiport address wins over a table entry with the same key.
      put(MPA, 12'h00a, 12'h00a, 2'h0, 3'b111, 3'h0, 9'h001);
      multiport_enable = 1'b1;
      lookup(MPA, 12'h00a, 4'h0);
      res_is(FWD_MULTIPORT, 9'h0c3);
      multiport_enable = 1'b0;
      lookup(MPA, 12'h00a, 4'h0);
      chk(res_kind, FWD_UNICAST);
      // Each multicast class has its own fail-forward bit and map.
      mc_lookup_fail_forward = 2'b01;
      lookup(48'h01005e7f0001, 12'h00a, 4'h0);
      res_is(FWD_FAIL, 9'h02b);
      lookup(48'h0180c2000030, 12'h00a, 4'h0);
      res_is(FWD_FLOOD, 9'h1be);
      mc_lookup_fail_forward = 2'b10;
      lookup(48'h0180c2000030, 12'h00a, 4'h0);
      res_is(FWD_FAIL, 9'h150);
      lookup(48'h01005e7f0001, 12'h00a, 4'h1);
      res_is(FWD_FLOOD, 9'h1bd);
      finish_test();
   end

   // Watchdog: the scenarios need under a thousand cycles.
   initial begin
      repeat (3000) @(posedge clock);
      fail_count++;
      finish_test();
   end

endmodule : l2_address_resolution_lookup_tb_top

bind l2_address_resolution_lookup l2_lookup_chk i_l2_lookup_chk (
   .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
   .flood_eligible(flood_eligible), .tbl_rd_en(tbl_rd_en), .tbl_rd_index(tbl_rd_index),
   .tbl_rd_bank(tbl_rd_bank), .res_valid(res_valid), .res_kind(res_kind),
   .res_port_mask(res_port_mask), .res_tc_valid(res_tc_valid), .res_hit_age(res_hit_age));
